// file: acsp_params.svh
// Purpose: Constants for the two-wire accelerometer slave port and its master
// Assumes: One 20 MHz system clock on both ends
// Notes: Definitions only
`ifndef ACSP_PARAMS_SVH
`define ACSP_PARAMS_SVH
`define ACSP_CLK_HZ 20000000
`define ACSP_ADDR_FIXED 6'h07
`define ACSP_BYTE_BITS 4'h8
`define ACSP_BIT_LAST 3'h7
`define ACSP_ACK_LOW 1'b0
`define ACSP_DIR_READ 1'b1
`define ACSP_DIR_WRITE 1'b0
`define ACSP_PTR_RESET 8'h00
`define ACSP_STRETCH_CYC 4'h3
`define ACSP_HALF_BIT_NS 2500
`define ACSP_HALF_BIT_CYC ((`ACSP_HALF_BIT_NS * (`ACSP_CLK_HZ / 1000000) + 999) / 1000)
`endif

// file: acsp_pkg.sv
// Purpose: Shared types for the slave port and its master
// Assumes: Constants come from acsp_params.svh
// Notes: Types only
`default_nettype none
package acsp_pkg;
	typedef enum logic [1:0] {ACSP_OP_WRITE, ACSP_OP_READ, ACSP_OP_PTR} acsp_op_t;
	typedef logic [7:0] acsp_byte_t;
endpackage : acsp_pkg
`default_nettype wire

// file: acsp_bus_if.sv
// Purpose: Two-wire bus between master and slave port
// Assumes: Open-drain lines; enable low means the party pulls low
// Notes: Wire level is the AND of the released-or-low drives
`timescale 1ns/100ps
`default_nettype none
interface acsp_bus_if;
	logic m_scl_oe_b;
	logic m_sda_oe_b;
	logic s_scl_oe_b;
	logic s_sda_oe_b;
	logic scl;
	logic sda;
	assign scl = m_scl_oe_b & s_scl_oe_b;
	assign sda = m_sda_oe_b & s_sda_oe_b;
	modport slave (input scl, input sda, output s_scl_oe_b, output s_sda_oe_b);
	modport master (input scl, input sda, output m_scl_oe_b, output m_sda_oe_b);
endinterface : acsp_bus_if
`default_nettype wire

// file: acsp_slave.sv
// Purpose: Slave port of the accelerometer on the two-wire bus
// Assumes: Bus lines synchronous to clk_i; register file outside on wr/rd strobes
// Notes: Functional notes follow
`timescale 1ns/100ps
`default_nettype none
`include "acsp_params.svh"
module acsp_slave
	import acsp_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_b_i,
	acsp_bus_if.slave bus,
	input wire logic addr_sel_i,
	output logic wr_stb_o,
	output logic rd_stb_o,
	output acsp_byte_t reg_addr_o,
	output acsp_byte_t wr_data_o,
	input wire acsp_byte_t rd_data_i,
	output logic busy_o
);
	typedef enum {ST_IDLE, ST_ADDR, ST_PTR, ST_WDATA, ST_RDATA, ST_IGNORE} acsp_state_t;
	acsp_state_t state_r;
	logic scl_q_r;
	logic sda_q_r;
	logic scl_r;
	logic sda_r;
	logic [3:0] bit_r;
	acsp_byte_t shift_r;
	acsp_byte_t ptr_r;
	acsp_byte_t tx_r;
	logic ack_phase_r;
	logic rd_dir_r;
	logic master_nack_r;
	logic [3:0] stretch_r;
	logic scl_rise;
	logic scl_fall;
	logic start_c;
	logic stop_c;
	logic s_sda_r;
	logic s_scl_r;

	// Line sampling for edge detection
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			scl_q_r <= 1'b1;
			sda_q_r <= 1'b1;
			scl_r <= 1'b1;
			sda_r <= 1'b1;
		end else begin
			scl_q_r <= bus.scl;
			sda_q_r <= bus.sda;
			scl_r <= scl_q_r;
			sda_r <= sda_q_r;
		end
	end
	assign scl_rise = scl_q_r & ~scl_r;
	assign scl_fall = ~scl_q_r & scl_r;
	assign start_c = scl_q_r & scl_r & sda_r & ~sda_q_r;
	assign stop_c = scl_q_r & scl_r & ~sda_r & sda_q_r;

	function automatic logic addr_hit(input acsp_byte_t b, input logic sel);
		addr_hit = (b[7:1] == {`ACSP_ADDR_FIXED, sel});
	endfunction : addr_hit

	// Clock fall that closes the eighth bit of a byte
	function automatic logic at_byte_end(input logic fall, input logic ack, input logic [3:0] cnt);
		at_byte_end = fall && !ack && (cnt == `ACSP_BYTE_BITS);
	endfunction : at_byte_end

	// Frame state and bit count
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			state_r <= ST_IDLE;
			bit_r <= 4'h0;
			shift_r <= 8'h00;
			ack_phase_r <= 1'b0;
			rd_dir_r <= 1'b0;
			master_nack_r <= 1'b0;
		end else if (start_c) begin
			state_r <= ST_ADDR;
			bit_r <= 4'h0;
			ack_phase_r <= 1'b0;
			master_nack_r <= 1'b0;
		end else if (stop_c) begin
			state_r <= ST_IDLE;
		end else if (scl_rise && state_r != ST_IDLE) begin
			if (ack_phase_r) begin
				if (state_r == ST_RDATA)
					master_nack_r <= sda_q_r;
			end else begin
				shift_r <= {shift_r[6:0], sda_q_r};
				bit_r <= bit_r + 4'h1;
			end
		end else if (scl_fall && state_r != ST_IDLE && state_r != ST_IGNORE) begin
			if (!ack_phase_r && bit_r == `ACSP_BYTE_BITS) begin
				ack_phase_r <= 1'b1;
				bit_r <= 4'h0;
				unique case (state_r)
					ST_ADDR: begin
						if (!addr_hit(shift_r, addr_sel_i)) begin
							state_r <= ST_IGNORE;
						end else begin
							rd_dir_r <= shift_r[0];
						end
					end
					ST_PTR: state_r <= ST_WDATA;
					ST_WDATA, ST_RDATA: state_r <= state_r;
				endcase
			end else if (ack_phase_r) begin
				ack_phase_r <= 1'b0;
				if (state_r == ST_ADDR)
					state_r <= rd_dir_r ? ST_RDATA : ST_PTR;
				else if (state_r == ST_RDATA && master_nack_r)
					state_r <= ST_IGNORE;
			end
		end
	end

	// Pointer, strobes and read fetch
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			ptr_r <= `ACSP_PTR_RESET;
			wr_stb_o <= 1'b0;
			rd_stb_o <= 1'b0;
			wr_data_o <= 8'h00;
			reg_addr_o <= `ACSP_PTR_RESET;
			tx_r <= 8'h00;
			stretch_r <= 4'h0;
		end else begin
			wr_stb_o <= 1'b0;
			rd_stb_o <= 1'b0;
			reg_addr_o <= ptr_r;
			if (at_byte_end(scl_fall, ack_phase_r, bit_r)) begin
				if (state_r == ST_PTR)
					ptr_r <= shift_r;
				else if (state_r == ST_WDATA) begin
					wr_stb_o <= 1'b1;
					wr_data_o <= shift_r;
					ptr_r <= ptr_r + 8'h01;
				end
			end
			if (scl_fall && ack_phase_r && state_r == ST_RDATA && master_nack_r)
				stretch_r <= 4'h0;
			else if (scl_fall && ack_phase_r &&
				((state_r == ST_ADDR && rd_dir_r) || (state_r == ST_RDATA && !master_nack_r))) begin
				rd_stb_o <= 1'b1;
				stretch_r <= `ACSP_STRETCH_CYC;
			end else if (stretch_r != 4'h0) begin
				stretch_r <= stretch_r - 4'h1;
				if (stretch_r == 4'h1) begin
					tx_r <= rd_data_i;
					ptr_r <= ptr_r + 8'h01;
				end
			end else if (scl_fall && state_r == ST_RDATA && !ack_phase_r)
				tx_r <= {tx_r[6:0], 1'b1};
		end
	end

	// Open-drain drive of the lines
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			s_sda_r <= 1'b1;
			s_scl_r <= 1'b1;
		end else begin
			s_scl_r <= !(stretch_r > 4'h1);
			if (start_c || stop_c)
				s_sda_r <= 1'b1;
			else if (at_byte_end(scl_fall, ack_phase_r, bit_r) && state_r inside {ST_ADDR, ST_PTR, ST_WDATA})
				s_sda_r <= (state_r == ST_ADDR) ? !addr_hit(shift_r, addr_sel_i) : `ACSP_ACK_LOW;
			else if (state_r == ST_RDATA && !ack_phase_r && stretch_r == 4'h1)
				s_sda_r <= rd_data_i[7];
			else if (scl_fall && state_r == ST_RDATA && !ack_phase_r && bit_r != `ACSP_BYTE_BITS)
				s_sda_r <= tx_r[6];
			else if (scl_fall)
				s_sda_r <= 1'b1;
		end
	end
	assign bus.s_sda_oe_b = s_sda_r;
	assign bus.s_scl_oe_b = s_scl_r;

	// Busy from start to stop
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i)
			busy_o <= 1'b0;
		else
			busy_o <= (state_r != ST_IDLE) && !stop_c;
	end
endmodule : acsp_slave
`default_nettype wire

// file: acsp_master.sv
// Purpose: Bus master that drives the slave port
// Assumes: One command at a time; start_i pulse with op, address, data
// Notes: Bit timing from a half-bit counter; waits while clock held low
`timescale 1ns/100ps
`default_nettype none
`include "acsp_params.svh"
module acsp_master
	import acsp_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_b_i,
	acsp_bus_if.master bus,
	input wire logic start_i,
	input wire acsp_op_t op_i,
	input wire logic [6:0] dev_addr_i,
	input wire acsp_byte_t ptr_i,
	input wire acsp_byte_t wdata_i,
	output logic done_o,
	output logic nack_o,
	output acsp_byte_t rdata_o
);
	typedef enum {M_IDLE, M_START, M_BIT, M_STOP, M_DONE} acsp_mstate_t;
	acsp_mstate_t st_r;
	logic [7:0] cnt_r;
	logic [1:0] phase_r;
	logic [3:0] bit_r;
	logic [1:0] byte_r;
	acsp_byte_t sh_r;
	acsp_op_t op_r;
	logic scl_r, sda_r, rd_byte;
	logic [6:0] addr_r;
	acsp_byte_t ptr_r, wd_r;
	assign bus.m_scl_oe_b = scl_r;
	assign bus.m_sda_oe_b = sda_r;
	// Byte 0 address+W, 1 pointer, 2 data, 3 read address (+R)
	assign rd_byte = (op_r == ACSP_OP_READ) && (byte_r == 2'h2);

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			st_r <= M_IDLE;
			cnt_r <= 8'h00;
			phase_r <= 2'h0;
			bit_r <= 4'h0;
			byte_r <= 2'h0;
			sh_r <= 8'h00;
			op_r <= ACSP_OP_WRITE;
			scl_r <= 1'b1;
			sda_r <= 1'b1;
			addr_r <= 7'h00;
			ptr_r <= 8'h00;
			wd_r <= 8'h00;
			done_o <= 1'b0;
			nack_o <= 1'b0;
			rdata_o <= 8'h00;
		end else begin
			done_o <= 1'b0;
			if (cnt_r != 8'h00) begin
				cnt_r <= cnt_r - 8'h01;
			end else begin
				cnt_r <= 8'(`ACSP_HALF_BIT_CYC);
				unique case (st_r)
					M_IDLE: if (start_i) begin
						op_r <= op_i;
						addr_r <= dev_addr_i;
						ptr_r <= ptr_i;
						wd_r <= wdata_i;
						byte_r <= 2'h0;
						nack_o <= 1'b0;
						st_r <= M_START;
						phase_r <= 2'h0;
					end
					M_START: begin
						if (phase_r == 2'h0) begin
							scl_r <= 1'b1;
							sda_r <= 1'b1;
							phase_r <= 2'h1;
						end else if (phase_r == 2'h1) begin
							sda_r <= 1'b0;
							phase_r <= 2'h2;
						end else begin
							scl_r <= 1'b0;
							sh_r <= {addr_r, op_r == ACSP_OP_READ && byte_r == 2'h3};
							bit_r <= 4'h0;
							phase_r <= 2'h0;
							st_r <= M_BIT;
						end
					end
					M_BIT: begin
						if (phase_r == 2'h0) begin
							if (bit_r < `ACSP_BYTE_BITS)
								sda_r <= rd_byte ? 1'b1 : sh_r[7];
							else
								sda_r <= 1'b1;
							phase_r <= 2'h1;
						end else if (phase_r == 2'h1) begin
							scl_r <= 1'b1;
							phase_r <= 2'h2;
						end else if (bus.scl) begin
							scl_r <= 1'b0;
							phase_r <= 2'h0;
							if (bit_r < `ACSP_BYTE_BITS) begin
								sh_r <= {sh_r[6:0], bus.sda};
								bit_r <= bit_r + 4'h1;
							end else if (rd_byte) begin
								rdata_o <= sh_r;
								st_r <= M_STOP;
							end else if (bus.sda) begin
								nack_o <= 1'b1;
								st_r <= M_STOP;
							end else begin
								bit_r <= 4'h0;
								if (byte_r == 2'h0) begin
									byte_r <= 2'h1;
									sh_r <= {1'b0, ptr_r[6:0]};
								end else if (byte_r == 2'h1 && op_r == ACSP_OP_WRITE) begin
									byte_r <= 2'h2;
									sh_r <= wd_r;
								end else if (byte_r == 2'h1 && op_r == ACSP_OP_READ) begin
									byte_r <= 2'h3;
									st_r <= M_START;
								end else if (byte_r == 2'h3) begin
									byte_r <= 2'h2;
									sh_r <= 8'hff;
								end else
									st_r <= M_STOP;
							end
						end
					end
					M_STOP: begin
						if (phase_r == 2'h0) begin
							sda_r <= 1'b0;
							phase_r <= 2'h1;
						end else if (phase_r == 2'h1) begin
							scl_r <= 1'b1;
							phase_r <= 2'h2;
						end else begin
							sda_r <= 1'b1;
							phase_r <= 2'h0;
							st_r <= M_DONE;
						end
					end
					M_DONE: begin
						done_o <= 1'b1;
						st_r <= M_IDLE;
					end
				endcase
			end
		end
	end
endmodule : acsp_master
`default_nettype wire

// file: acsp_bus_monitor.sv
// Purpose: Wire checks on the two-wire bus
// Assumes: One clock domain
// Notes: Bit count restarts at every start
`timescale 1ns/100ps
`default_nettype none
module acsp_bus_monitor (
	input wire logic clk_i,
	input wire logic rst_b_i,
	input wire logic m_scl_oe_b,
	input wire logic m_sda_oe_b,
	input wire logic s_scl_oe_b,
	input wire logic s_sda_oe_b,
	input wire logic scl,
	input wire logic sda
);
	logic sda_r;
	logic scl_r;
	logic frame_r;
	logic [3:0] bit_r;
	logic [15:0] len_r;
	wire logic strt = scl & sda_r & !sda;
	wire logic stp = scl & !sda_r & sda;
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			sda_r <= 1'b1;
			scl_r <= 1'b1;
			frame_r <= 1'b0;
			bit_r <= 4'h0;
			len_r <= 16'h0000;
		end else begin
			sda_r <= sda;
			scl_r <= scl;
			frame_r <= strt | (frame_r & !stp);
			len_r <= (frame_r & !strt) ? len_r + 16'h0001 : 16'h0000;
			if (strt) begin
				bit_r <= 4'h0;
			end else if (scl & !scl_r) begin
				bit_r <= (bit_r == 4'h8) ? 4'h0 : bit_r + 4'h1;
			end
		end
	end
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rst_b_i);
	chk_stretch_len: assert property ($fell(s_scl_oe_b) |-> ##[1:6] s_scl_oe_b)
		else $error("Clock held low too long");
	chk_hold_low_only: assert property ($fell(s_scl_oe_b) |-> !$past(scl))
		else $error("Slave pulled a high clock");
	chk_stretch_frame: assert property (!s_scl_oe_b |-> frame_r)
		else $error("Clock held outside a frame");
	chk_sda_on_low: assert property ($changed(s_sda_oe_b) |-> !scl)
		else $error("Slave moved data while clock high");
	chk_start_free: assert property (strt |-> s_sda_oe_b && s_scl_oe_b)
		else $error("Slave driving at start");
	chk_no_contend: assert property (scl && !s_sda_oe_b |-> m_sda_oe_b)
		else $error("Both parties drive data");
	chk_wait_hold: assert property (!s_scl_oe_b |-> $stable(m_sda_oe_b))
		else $error("Master moved data during wait");
	chk_frame_len: assert property (frame_r |-> len_r < 16'h2ee0)
		else $error("Frame not closed by stop");
	chk_ack_steady: assert property ($rose(scl) && bit_r == 4'h8 && !s_sda_oe_b |-> !s_sda_oe_b [*8])
		else $error("Acknowledge not held through high");
endmodule : acsp_bus_monitor
`default_nettype wire

// file: tb_top.sv
// Purpose: Joins master and slave port and checks transfers
// Assumes: 20 MHz clock, half bit of 50 clocks
// Notes: Register file modelled as pointer xor 3c
`timescale 1ns/100ps
`default_nettype none
module tb_top
	import acsp_pkg::*;
	;
	logic clk_i = 1'b0;
	logic rst_b_i = 1'b0;
	logic addr_sel_i = 1'b0;
	logic start_i = 1'b0;
	acsp_op_t op_i = ACSP_OP_WRITE;
	logic [6:0] dev_addr_i = 7'h00;
	acsp_byte_t ptr_i = 8'h00;
	acsp_byte_t wdata_i = 8'h00;
	acsp_byte_t rd_data_i = 8'h00;
	logic wr_stb_o, rd_stb_o, busy_o, done_o, nack_o;
	acsp_byte_t reg_addr_o, wr_data_o, rdata_o, wa, wd;
	int n_fail = 0;
	int cmp_count = 0;
	int n_wr = 0;
	int n_rd = 0;
	acsp_bus_if bus_if ();
	always #25 clk_i = ~clk_i;
	acsp_slave acsp_slave_i (.clk_i(clk_i), .rst_b_i(rst_b_i), .bus(bus_if), .addr_sel_i(addr_sel_i),
		.wr_stb_o(wr_stb_o), .rd_stb_o(rd_stb_o), .reg_addr_o(reg_addr_o), .wr_data_o(wr_data_o),
		.rd_data_i(rd_data_i), .busy_o(busy_o));
	acsp_master acsp_master_i (.clk_i(clk_i), .rst_b_i(rst_b_i), .bus(bus_if), .start_i(start_i),
		.op_i(op_i), .dev_addr_i(dev_addr_i), .ptr_i(ptr_i), .wdata_i(wdata_i), .done_o(done_o),
		.nack_o(nack_o), .rdata_o(rdata_o));
	acsp_bus_monitor acsp_bus_monitor_i (.clk_i(clk_i), .rst_b_i(rst_b_i), .m_scl_oe_b(bus_if.m_scl_oe_b),
		.m_sda_oe_b(bus_if.m_sda_oe_b), .s_scl_oe_b(bus_if.s_scl_oe_b), .s_sda_oe_b(bus_if.s_sda_oe_b),
		.scl(bus_if.scl), .sda(bus_if.sda));
	always @(posedge clk_i) begin
		rd_data_i <= reg_addr_o ^ 8'h3c;
		if (rd_stb_o === 1'b1)
			n_rd <= n_rd + 1;
		if (wr_stb_o === 1'b1) begin
			n_wr <= n_wr + 1;
			wa <= reg_addr_o;
			wd <= wr_data_o;
		end
	end
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		cmp_count++;
		if (got !== exp) begin
			n_fail++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task automatic xfer(input acsp_op_t op, input logic [6:0] da, input acsp_byte_t p, input acsp_byte_t d,
		input logic sel);
		int i;
		@(posedge clk_i);
		addr_sel_i <= sel;
		op_i <= op;
		dev_addr_i <= da;
		ptr_i <= p;
		wdata_i <= d;
		start_i <= 1'b1;
		i = 0;
		do begin
			@(negedge clk_i);
			i++;
		end while (bus_if.sda !== 1'b0 && i < 200);
		@(posedge clk_i);
		start_i <= 1'b0;
		i = 0;
		do begin
			@(negedge clk_i);
			i++;
		end while (done_o !== 1'b1 && i < 20000);
		chk(done_o, 1'b1);
	endtask : xfer
	task automatic sc_write;
		xfer(ACSP_OP_WRITE, 7'h0e, 8'h05, 8'h00, 1'b0);
		chk(wd, 8'h00);
		xfer(ACSP_OP_WRITE, 7'h0e, 8'h05, 8'ha5, 1'b0);
		chk(nack_o, 1'b0);
		chk(n_wr, 2);
		chk(wa, 8'h05);
		chk(wd, 8'ha5);
		chk(reg_addr_o, 8'h06);
		chk(bus_if.scl & bus_if.sda, 1'b1);
	endtask : sc_write
	task automatic sc_read;
		xfer(ACSP_OP_READ, 7'h0e, 8'h1f, 8'h00, 1'b0);
		chk(nack_o, 1'b0);
		chk(rdata_o, 8'h23);
		chk(reg_addr_o, 8'h20);
		chk(n_rd, 1);
		chk(bus_if.sda, 1'b1);
	endtask : sc_read
	task automatic sc_match;
		xfer(ACSP_OP_WRITE, 7'h0f, 8'h11, 8'h22, 1'b0);
		chk(nack_o, 1'b1);
		chk(n_wr, 2);
		chk(reg_addr_o, 8'h20);
		chk(busy_o, 1'b0);
		xfer(ACSP_OP_WRITE, 7'h0e, 8'h11, 8'h22, 1'b1);
		chk(nack_o, 1'b1);
		xfer(ACSP_OP_WRITE, 7'h0f, 8'h7f, 8'h5a, 1'b1);
		chk(nack_o, 1'b0);
		chk(wa, 8'h7f);
		chk(wd, 8'h5a);
		chk(reg_addr_o, 8'h80);
	endtask : sc_match
	task automatic complete_run;
		$display("Comparisons %0d mismatches %0d", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : complete_run
	initial begin
		repeat (5) @(posedge clk_i);
		rst_b_i <= 1'b1;
		sc_write();
		sc_read();
		sc_match();
		complete_run();
	end
	initial begin
		repeat (60000) @(posedge clk_i);
		n_fail++;
		complete_run();
	end
endmodule : tb_top
`default_nettype wire
